// >>> smbus_slave_defines.vh
`ifndef SMBUS_SLAVE_DEFINES_VH
`define SMBUS_SLAVE_DEFINES_VH
`define CLK_FREQ_HZ 50000000
`define GLITCH_NS 100
`define GLITCH_CYCLES ((`GLITCH_NS * 50 + 999) / 1000)
`define TIMEOUT_MIN_MS 25
`define TIMEOUT_CYCLES (`TIMEOUT_MIN_MS * (`CLK_FREQ_HZ / 1000))
`define POWERUP_MS 100
`define POWERUP_CYCLES (`POWERUP_MS * (`CLK_FREQ_HZ / 1000))
`define PREAMBLE_SENSE 4'h3
`define PREAMBLE_MEMORY 4'hA
`define FIFO_DEPTH 32
`define FIFO_WIDTH 8
`endif

// >>> byte_fifo.v
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clk,
  input wire reset_n,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ff;
  reg [AW:0] rd_ff;
  wire full = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
  wire empty = (wr_ff == rd_ff);
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem[rd_ff[AW-1:0]];
  always @(posedge clk) begin
    if (in_valid && !full) begin
      mem[wr_ff[AW-1:0]] <= in_data;
    end
  end
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ff <= {(AW+1){1'b0}};
      rd_ff <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ff <= rd_ff + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> smbus_slave_port.v
`timescale 1ns/1ps
`include "smbus_slave_defines.vh"
`default_nettype none
module smbus_slave_port #(
  parameter LATER_REVISION = 1'b1,
  parameter TIMEOUT_CYCLES = `TIMEOUT_CYCLES,
  parameter POWERUP_CYCLES = `POWERUP_CYCLES
) (
  input wire clk,
  input wire reset_n,
  input wire memory_reset_n,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_n,
  input wire strap_select_bit0,
  input wire strap_select_bit1,
  input wire strap_select_bit2,
  output wire [7:0] rx_data,
  output wire rx_valid,
  input wire rx_ready,
  output reg rx_is_memory,
  output reg rx_first,
  input wire [7:0] tx_data,
  output wire tx_req,
  output reg sense_converting,
  output reg sense_result_valid,
  output reg memory_standby,
  output reg timeout_event
);
  localparam S_IDLE = 6'h01;
  localparam S_ADDR = 6'h02;
  localparam S_ACK = 6'h04;
  localparam S_RX = 6'h08;
  localparam S_TX = 6'h10;
  localparam S_MACK = 6'h20;

  reg [1:0] scl_sync_ff;
  reg [1:0] sda_sync_ff;
  reg [2:0] scl_flt_cnt_ff;
  reg [2:0] sda_flt_cnt_ff;
  reg scl_ff;
  reg sda_ff;
  reg scl_prev_ff;
  reg sda_prev_ff;
  reg [5:0] state_ff;
  reg [3:0] bit_cnt_ff;
  reg [7:0] shift_ff;
  reg rw_ff;
  reg memory_sel_ff;
  reg first_ff;
  reg pull_low_ff;
  reg busy_ff;
  reg ack_pending_ff;
  reg [31:0] low_cnt_ff;
  reg [31:0] pu_cnt_ff;
  reg [2:0] strap_meta_ff;
  reg [2:0] strap_ff;
  reg [7:0] rx_data_ff;
  reg rx_valid_ff;
  reg nxt_pull_low;

  wire scl_rise = scl_ff & ~scl_prev_ff;
  wire scl_fall = ~scl_ff & scl_prev_ff;
  wire start_cond = scl_ff & scl_prev_ff & sda_prev_ff & ~sda_ff;
  wire stop_cond = scl_ff & scl_prev_ff & ~sda_prev_ff & sda_ff;
  wire timed_out = (low_cnt_ff >= TIMEOUT_CYCLES[31:0]);
  // earlier revision: memory sessions have no timeout, so clocking down to DC works
  wire timeout_applies = ~memory_sel_ff | LATER_REVISION;
  wire fifo_in_ready;

  // open drain: line value is always low, enable low means pulled
  assign sda_out = 1'b0;
  assign sda_oe_n = ~pull_low_ff;
  assign tx_req = (state_ff == S_TX) && scl_fall && (bit_cnt_ff == 4'h0);

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_sync_ff <= 2'b11;
      sda_sync_ff <= 2'b11;
      scl_flt_cnt_ff <= 3'h0;
      sda_flt_cnt_ff <= 3'h0;
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], scl_in};
      sda_sync_ff <= {sda_sync_ff[0], sda_in};
      scl_prev_ff <= scl_ff;
      sda_prev_ff <= sda_ff;
      // a level must persist past the noise window before it is accepted
      if (scl_sync_ff[1] == scl_ff) begin
        scl_flt_cnt_ff <= 3'h0;
      end else if (scl_flt_cnt_ff == `GLITCH_CYCLES) begin
        scl_ff <= scl_sync_ff[1];
        scl_flt_cnt_ff <= 3'h0;
      end else begin
        scl_flt_cnt_ff <= scl_flt_cnt_ff + 3'h1;
      end
      if (sda_sync_ff[1] == sda_ff) begin
        sda_flt_cnt_ff <= 3'h0;
      end else if (sda_flt_cnt_ff == `GLITCH_CYCLES) begin
        sda_ff <= sda_sync_ff[1];
        sda_flt_cnt_ff <= 3'h0;
      end else begin
        sda_flt_cnt_ff <= sda_flt_cnt_ff + 3'h1;
      end
    end
  end

  // straps resampled every cycle after release; undriven pins arrive as zero via pulls
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_meta_ff <= 3'h0;
      strap_ff <= 3'h0;
    end else begin
      // two stages: straps are pins and may move at any time
      strap_meta_ff <= {strap_select_bit2, strap_select_bit1, strap_select_bit0};
      strap_ff <= strap_meta_ff;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt_ff <= 32'h0;
    end else if (scl_ff || !busy_ff || !timeout_applies) begin
      low_cnt_ff <= 32'h0;
    end else if (!timed_out) begin
      low_cnt_ff <= low_cnt_ff + 32'h1;
    end
  end

  // sensor conversion starts by itself; result trusted after power-up delay
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sense_converting <= 1'b0;
      sense_result_valid <= 1'b0;
      pu_cnt_ff <= 32'h0;
    end else begin
      sense_converting <= 1'b1;
      if (pu_cnt_ff >= POWERUP_CYCLES[31:0]) begin
        sense_result_valid <= 1'b1;
      end else begin
        pu_cnt_ff <= pu_cnt_ff + 32'h1;
      end
    end
  end

  always @(posedge clk or negedge memory_reset_n) begin
    if (!memory_reset_n) begin
      memory_standby <= 1'b0;
    end else begin
      memory_standby <= ~busy_ff | ~memory_sel_ff;
    end
  end

  always @* begin
    nxt_pull_low = pull_low_ff;
    if (scl_fall) begin
      case (state_ff)
        S_ACK: nxt_pull_low = ack_pending_ff;
        // first bit straight from the request word, later ones from the shifter
        S_TX: nxt_pull_low = (bit_cnt_ff == 4'h0) ? ~tx_data[7] : ~shift_ff[7];
        default: nxt_pull_low = 1'b0;
      endcase
    end
  end

  // master owns clock and start/stop; slave only follows them
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= S_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h0;
      rw_ff <= 1'b0;
      memory_sel_ff <= 1'b0;
      first_ff <= 1'b0;
      pull_low_ff <= 1'b0;
      busy_ff <= 1'b0;
      ack_pending_ff <= 1'b0;
      rx_data_ff <= 8'h0;
      rx_valid_ff <= 1'b0;
      rx_is_memory <= 1'b0;
      rx_first <= 1'b0;
      timeout_event <= 1'b0;
    end else begin
      timeout_event <= 1'b0;
      if (rx_valid_ff && fifo_in_ready) begin
        rx_valid_ff <= 1'b0;
      end
      // busy gate: the stale count must not fire a second pulse
      if (timed_out && timeout_applies && busy_ff) begin
        state_ff <= S_IDLE;
        pull_low_ff <= 1'b0;
        busy_ff <= 1'b0;
        timeout_event <= 1'b1;
      end else if (start_cond) begin
        state_ff <= S_ADDR;
        busy_ff <= 1'b1;
        bit_cnt_ff <= 4'h0;
        pull_low_ff <= 1'b0;
      end else if (stop_cond) begin
        state_ff <= S_IDLE;
        busy_ff <= 1'b0;
        pull_low_ff <= 1'b0;
      end else begin
        pull_low_ff <= nxt_pull_low;
        if (scl_fall && state_ff == S_TX) begin
          shift_ff <= (bit_cnt_ff == 4'h0) ? {tx_data[6:0], 1'b0} : {shift_ff[6:0], 1'b0};
        end
        if (scl_rise) begin
          case (state_ff)
            S_ADDR, S_RX: begin
              shift_ff <= {shift_ff[6:0], sda_ff};
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
              if (bit_cnt_ff == 4'h7) begin
                if (state_ff == S_ADDR) begin
                  // ignore anyone else's address
                  if ({shift_ff[2:0], sda_ff} != {strap_ff, sda_ff} ||
                      (shift_ff[6:3] != `PREAMBLE_SENSE &&
                       shift_ff[6:3] != `PREAMBLE_MEMORY)) begin
                    state_ff <= S_IDLE;
                    busy_ff <= 1'b0;
                  end else begin
                    memory_sel_ff <= (shift_ff[6:3] == `PREAMBLE_MEMORY);
                    rw_ff <= sda_ff;
                    first_ff <= 1'b1;
                    state_ff <= S_ACK;
                    ack_pending_ff <= 1'b1;
                  end
                end else if (fifo_in_ready) begin
                  rx_data_ff <= {shift_ff[6:0], sda_ff};
                  rx_valid_ff <= 1'b1;
                  rx_is_memory <= memory_sel_ff;
                  rx_first <= first_ff;
                  first_ff <= 1'b0;
                  state_ff <= S_ACK;
                  ack_pending_ff <= 1'b1;
                end else begin
                  // full buffer: byte dropped and left unacknowledged
                  state_ff <= S_IDLE;
                  busy_ff <= 1'b0;
                end
              end
            end
            // leave the ack slot on its own rise so it is not counted as data
            S_ACK: begin
              ack_pending_ff <= 1'b0;
              state_ff <= rw_ff ? S_TX : S_RX;
              bit_cnt_ff <= 4'h0;
            end
            S_TX: begin
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
              if (bit_cnt_ff == 4'h7) begin
                state_ff <= S_MACK;
              end
            end
            S_MACK: begin
              if (sda_ff) begin
                state_ff <= S_IDLE;
              end else begin
                state_ff <= S_TX;
                bit_cnt_ff <= 4'h0;
              end
            end
            default: begin
              bit_cnt_ff <= bit_cnt_ff;
            end
          endcase
        end
      end
    end
  end

  byte_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH),
    .AW(5)
  ) rx_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_data(rx_data_ff),
    .in_valid(rx_valid_ff),
    .in_ready(fifo_in_ready),
    .out_data(rx_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready)
  );
endmodule
`default_nettype wire

// >>> smbus_slave_port_props.sv
`timescale 1ns/1ps
`default_nettype none
module smbus_slave_port_props #(
  parameter TIMEOUT_CYCLES = 2000,
  parameter POWERUP_CYCLES = 1000
) (
  input wire clk,
  input wire reset_n,
  input wire memory_reset_n,
  input wire scl_in,
  input wire sda_out,
  input wire sda_oe_n,
  input wire [7:0] rx_data,
  input wire rx_valid,
  input wire rx_ready,
  input wire tx_req,
  input wire sense_converting,
  input wire sense_result_valid,
  input wire memory_standby,
  input wire timeout_event
);
  int up_cnt;
  int low_cnt;
  // up_cnt saturates so a long run never wraps; low_cnt clears whenever scl_in is high
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      up_cnt <= 0;
      low_cnt <= 0;
    end else begin
      up_cnt <= (up_cnt > POWERUP_CYCLES + 9) ? up_cnt : up_cnt + 1;
      low_cnt <= scl_in ? 0 : low_cnt + 1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_open_drain: assert property (sda_out == 1'b0)
    else $error("sda driven high");
  a_timeout_window: assert property (timeout_event |->
    low_cnt >= TIMEOUT_CYCLES && low_cnt <= TIMEOUT_CYCLES * 7 / 5)
    else $error("timeout outside window");
  a_timeout_release: assert property (timeout_event |-> ##[1:3] sda_oe_n)
    else $error("sda held after timeout");
  a_timeout_once: assert property (timeout_event |=> !timeout_event)
    else $error("timeout repeated");
  a_sda_moves_low: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("sda moved while scl high");
  a_tx_on_fall: assert property (tx_req |-> !scl_in ##1 !tx_req)
    else $error("tx request misplaced");
  a_conv_start: assert property (up_cnt >= 2 |-> sense_converting)
    else $error("no conversion after reset");
  a_valid_early: assert property (sense_result_valid |-> up_cnt >= POWERUP_CYCLES - 2)
    else $error("result valid too early");
  a_valid_late: assert property (up_cnt > POWERUP_CYCLES + 4 |-> sense_result_valid)
    else $error("result valid too late");
  a_mem_reset: assert property (!memory_reset_n |-> !memory_standby)
    else $error("standby during memory reset");
  a_mem_standby: assert property ($rose(memory_reset_n) |-> ##[1:4] memory_standby)
    else $error("no standby after reset");
  a_fifo_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("fifo head lost");
endmodule
bind smbus_slave_port smbus_slave_port_props #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES),
  .POWERUP_CYCLES(POWERUP_CYCLES)
) u_props (.clk, .reset_n, .memory_reset_n, .scl_in, .sda_out, .sda_oe_n, .rx_data,
  .rx_valid, .rx_ready, .tx_req, .sense_converting, .sense_result_valid,
  .memory_standby, .timeout_event);
`default_nettype wire

// >>> smbus_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
  output logic scl,
  output logic sda_m,
  input wire logic sda_w
);
  // 2560 ns bit: the input pipe needs long phases
  localparam int Q = 640;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic start();
    #Q sda_m = 1'b1;
    #Q scl = 1'b1;
    #Q sda_m = 1'b0;
    #Q scl = 1'b0;
  endtask
  task automatic stop();
    #Q sda_m = 1'b0;
    #Q scl = 1'b1;
    #Q sda_m = 1'b1;
    #Q;
  endtask
  // msb first, ninth slot is the ack
  task automatic xfer(input logic [8:0] v, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      #Q sda_m = v[i];
      #Q scl = 1'b1;
      #(2 * Q) q[i] = sda_w;
      scl = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// >>> test_smbus_slave_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_smbus_slave_port;
  localparam int TO = 2000;
  localparam int PU = 1000;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic mem_rst_n = 1'b0;
  logic rx_ready = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic [2:0] strap = 3'h5;
  logic g_scl = 1'b0;
  logic g_sda = 1'b0;
  logic [8:0] q;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int to_cnt = 0;
  int req_cnt = 0;
  wire scl, sda_m, sda_out, sda_oe_n, rx_valid, rx_is_memory, rx_first, tx_req;
  wire sense_converting, sense_result_valid, memory_standby, timeout_event;
  wire [7:0] rx_data;
  // pulled-up wire; g_ terms inject short noise pulses
  wire sda_w = (sda_m ^ g_sda) & (sda_oe_n | sda_out);
  wire scl_w = scl ^ g_scl;
  always #10 clk = ~clk;
  smbus_slave_port #(.TIMEOUT_CYCLES(TO), .POWERUP_CYCLES(PU)) DUT (
    .clk, .reset_n, .memory_reset_n(mem_rst_n), .scl_in(scl_w), .sda_in(sda_w),
    .sda_out, .sda_oe_n, .strap_select_bit0(strap[0]), .strap_select_bit1(strap[1]),
    .strap_select_bit2(strap[2]), .rx_data, .rx_valid, .rx_ready, .rx_is_memory,
    .rx_first, .tx_data, .tx_req, .sense_converting, .sense_result_valid,
    .memory_standby, .timeout_event);
  smbus_host_model hm (.scl, .sda_m, .sda_w);
  task automatic finish_test();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (timeout_event === 1'b1) to_cnt <= to_cnt + 1;
    if (tx_req === 1'b1) req_cnt <= req_cnt + 1;
    if (cyc == 100000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [7:0] b, logic ack);
    hm.xfer({b, 1'b1}, q);
    chk("ack", 8'(ack), 8'(q[0]));
  endtask
  task automatic t_power();
    repeat (PU - 20) @(negedge clk);
    chk("valid", 8'h00, 8'(sense_result_valid));
    chk("conv", 8'h01, 8'(sense_converting));
    chk("standby", 8'h01, 8'(memory_standby));
    repeat (40) @(negedge clk);
    chk("valid", 8'h01, 8'(sense_result_valid));
  endtask
  task automatic t_write();
    hm.start();
    wr(8'h3A, 1'b0);
    fork
      wr(8'hA5, 1'b0);
      begin
        #1920 g_sda = 1'b1;
        #40 g_sda = 1'b0;
        #920 g_scl = 1'b1;
        #40 g_scl = 1'b0;
      end
    join
    hm.stop();
    chk("data", 8'hA5, rx_data);
    chk("mem", 8'h00, 8'(rx_is_memory));
    chk("first", 8'h01, 8'(rx_first));
    @(negedge clk) rx_ready = 1'b1;
    @(negedge clk) rx_ready = 1'b0;
    chk("empty", 8'h00, 8'(rx_valid));
  endtask
  task automatic t_refuse();
    hm.start();
    wr(8'h38, 1'b1);
    hm.start();
    wr(8'h5A, 1'b1);
    @(negedge clk) strap = 3'h0;
    hm.start();
    wr(8'h30, 1'b0);
    hm.stop();
    @(negedge clk) strap = 3'h5;
  endtask
  task automatic t_read();
    @(negedge clk) tx_data = 8'h3C;
    hm.start();
    wr(8'hAB, 1'b0);
    hm.xfer(9'h1FE, q);
    @(negedge clk) tx_data = 8'hC5;
    chk("read", 8'h3C, q[8:1]);
    hm.xfer(9'h1FF, q);
    chk("read", 8'hC5, q[8:1]);
    hm.stop();
    chk("free", 8'h01, 8'(sda_oe_n));
    chk("txreq", 8'h02, 8'(req_cnt));
  endtask
  task automatic t_timeout();
    @(negedge clk) tx_data = 8'h3C;
    hm.start();
    wr(8'hAB, 1'b0);
    repeat (20) @(negedge clk);
    chk("held", 8'h00, 8'(sda_oe_n));
    repeat (TO + 180) @(negedge clk);
    chk("tmo", 8'h01, 8'(to_cnt));
    chk("free", 8'h01, 8'(sda_oe_n));
    wr(8'hAA, 1'b1);
    hm.start();
    wr(8'hAA, 1'b0);
    hm.stop();
  endtask
  task automatic t_fill();
    hm.start();
    wr(8'hAA, 1'b0);
    for (int i = 0; i < 32; i++) wr(8'(64 + i), 1'b0);
    wr(8'h60, 1'b1);
    hm.stop();
    chk("tmo", 8'h01, 8'(to_cnt));
    chk("mem", 8'h01, 8'(rx_is_memory));
    chk("first", 8'h00, 8'(rx_first));
    for (int i = 0; i < 32; i++) begin
      chk("fifo", 8'(64 + i), rx_data);
      @(negedge clk) rx_ready = 1'b1;
      @(negedge clk) rx_ready = 1'b0;
    end
    chk("empty", 8'h00, 8'(rx_valid));
  endtask
  task automatic t_memrst();
    @(negedge clk) mem_rst_n = 1'b0;
    @(negedge clk) chk("standby", 8'h00, 8'(memory_standby));
    mem_rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("standby", 8'h01, 8'(memory_standby));
  endtask
  initial begin
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    mem_rst_n = 1'b1;
    t_power();
    t_write();
    t_refuse();
    t_read();
    t_timeout();
    t_fill();
    t_memrst();
    finish_test();
  end
endmodule
`default_nettype wire
